// >>> rtl/eptrk_pkg.sv
// constants and types for encoder position tracking
package eptrk_pkg;
    // position control scale
    localparam int unsigned EPTRK_CPR_BITS  = 13;
    localparam int unsigned EPTRK_POS_W     = 32;
    // native resolution codes
    localparam logic [2:0] EPTRK_RES_8K     = 3'h0;
    localparam logic [2:0] EPTRK_RES_32K    = 3'h1;
    localparam logic [2:0] EPTRK_RES_64K    = 3'h2;
    localparam logic [2:0] EPTRK_RES_1M     = 3'h3;
    localparam logic [2:0] EPTRK_RES_OLD1M  = 3'h4;
    localparam int unsigned EPTRK_RAW_W     = 20;
    // error codes
    localparam logic [7:0] EPTRK_ERR_NONE   = 8'h00;
    localparam logic [7:0] EPTRK_ERR_NOREF  = 8'h53;
    localparam logic [7:0] EPTRK_ERR_ENCTYP = 8'h51;
    localparam logic [7:0] EPTRK_ERR_BATT   = 8'h52;
    localparam logic [7:0] EPTRK_ERR_QUAD   = 8'h54;
    localparam logic [7:0] EPTRK_ERR_FOLLOW = 8'h55;
    // apb register byte addresses
    localparam logic [7:0] EPTRK_A_CTRL     = 8'h00;
    localparam logic [7:0] EPTRK_A_CMD      = 8'h04;
    localparam logic [7:0] EPTRK_A_STAT     = 8'h08;
    localparam logic [7:0] EPTRK_A_POS      = 8'h0c;
    localparam logic [7:0] EPTRK_A_LOLIM    = 8'h10;
    localparam logic [7:0] EPTRK_A_HILIM    = 8'h14;
    localparam logic [7:0] EPTRK_A_PRESET   = 8'h18;
    localparam logic [7:0] EPTRK_A_REFPOS   = 8'h1c;
    localparam logic [7:0] EPTRK_A_BIAS     = 8'h20;
    localparam logic [7:0] EPTRK_A_FINE     = 8'h24;
    // ctrl fields
    localparam int unsigned EPTRK_C_ABS     = 0;
    localparam int unsigned EPTRK_C_QUAD    = 1;
    localparam int unsigned EPTRK_C_FOLLOW  = 2;
    // cmd fields (write one to act; run is a level, rewritten on every cmd write)
    localparam int unsigned EPTRK_K_SEARCH  = 0;
    localparam int unsigned EPTRK_K_PRESET  = 1;
    localparam int unsigned EPTRK_K_CANCEL  = 2;
    localparam int unsigned EPTRK_K_CLRERR  = 3;
    localparam int unsigned EPTRK_K_RUN     = 4;
    // reset values
    localparam logic [31:0] EPTRK_RST_LOLIM = 32'h8000_0000;
    localparam logic [31:0] EPTRK_RST_HILIM = 32'h7fff_ffff;

    typedef enum logic [4:0] {
        EPTRK_S_DIAG  = 5'b00001,
        EPTRK_S_QUERY = 5'b00010,
        EPTRK_S_READ  = 5'b00100,
        EPTRK_S_RUN   = 5'b01000,
        EPTRK_S_SRCH  = 5'b10000
    } eptrk_state_t;

    // serial encoder sample from the amplifier link
    typedef struct packed {
        logic                     valid;
        logic [2:0]               res;
        logic [EPTRK_RAW_W-1:0]   angle;
        logic                     marker;
        logic                     referenced;
        logic                     batt_low;
        logic                     batt_lost;
    } eptrk_ser_t;

    // apb request
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } eptrk_apb_t;
endpackage

// >>> rtl/eptrk_quad.sv
// quadrature decoder: synchronisers, edge count and error detection
`timescale 1ns/1ns
`default_nettype none
module eptrk_quad
    import eptrk_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       srst,
    // encoder pins
    input  wire logic       pin_a,
    input  wire logic       pin_b,
    input  wire logic       pin_z,
    // decoded events
    output logic            step,
    output logic            up,
    output logic            quad_err,
    output logic            marker
);
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] prev;
    } eptrk_q_t;

    eptrk_q_t q_r, q_nxt;
    logic [1:0] now_ab;
    logic [1:0] old_ab;

    // first stage feeds only the second stage
    always_comb
    begin
        q_nxt      = q_r;
        q_nxt.s1   = {pin_z, pin_b, pin_a};
        q_nxt.s2   = q_r.s1;
        q_nxt.prev = q_r.s2;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            q_r <= '0;
        else
            q_r <= q_nxt;
    end

    assign now_ab = q_r.s2[1:0];
    assign old_ab = q_r.prev[1:0];
    // any single-channel edge counts; direction from gray order
    assign step     = (now_ab ^ old_ab) == 2'h1 || (now_ab ^ old_ab) == 2'h2;
    assign up       = (old_ab[0] ^ now_ab[1]);
    assign quad_err = (now_ab ^ old_ab) == 2'h3; // both moved together
    assign marker   = q_r.s2[2] & ~q_r.prev[2]; // rising marker edge
endmodule // eptrk_quad
`default_nettype wire

// >>> rtl/eptrk_scale.sv
// scales a serial encoder angle to 8192 counts per rev
`timescale 1ns/1ns
`default_nettype none
module eptrk_scale
    import eptrk_pkg::*;
(
    // sample in
    input  wire logic [2:0]             res,
    input  wire logic [EPTRK_RAW_W-1:0] angle,
    // scaled out
    output logic [EPTRK_CPR_BITS-1:0]   coarse,
    output logic                        supported
);
    // drop the extra fine bits for position control
    always_comb
    begin
        coarse    = angle[EPTRK_CPR_BITS-1:0];
        supported = 1'b1;
        if (res == EPTRK_RES_8K)
            coarse = angle[12:0];
        else if (res == EPTRK_RES_32K)
            coarse = angle[14:2];
        else if (res == EPTRK_RES_64K)
            coarse = angle[15:3];
        else if (res == EPTRK_RES_1M)
            coarse = angle[19:7];
        else
            supported = 1'b0; // old million-count type refused
    end
endmodule // eptrk_scale
`default_nettype wire

// >>> rtl/eptrk_top.sv
// position tracking core with apb registers
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module eptrk_top
    import eptrk_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // serial encoder link, already in this clock domain
    input  wire eptrk_ser_t  ser,
    output logic             ser_query,
    // quadrature pins
    input  wire logic        pin_a,
    input  wire logic        pin_b,
    input  wire logic        pin_z,
    // power-on diagnostics and nonvolatile bias store
    input  wire logic        diag_done,
    input  wire logic        nv_valid,
    input  wire logic [31:0] nv_bias,
    output logic             nv_write,
    output logic [31:0]      nv_wdata,
    // status to the motion engine
    output logic             position_ok_flag,
    output logic             motion_enable,
    output logic [31:0]      axis_pos,
    output logic [19:0]      fine_angle
);
    typedef struct packed {
        eptrk_state_t  st;
        logic [2:0]    ctrl;
        logic [31:0]   lolim;
        logic [31:0]   hilim;
        logic [31:0]   preset;
        logic [31:0]   refpos;
        logic [31:0]   bias;
        logic          bias_ok;
        logic [31:0]   pos;
        logic          ok;
        logic          run;
        logic [7:0]    err;
        logic          batt_low;
        logic          batt_lost;
        logic          nvw;
        logic [31:0]   rdata;
        logic [12:0]   last_c;
        logic [19:0]   fine;
    } eptrk_s_t;

    eptrk_s_t s_r, s_nxt;

    logic                q_step;
    logic                q_up;
    logic                q_err;
    logic                q_mark;
    logic [12:0]         coarse;
    logic                supported;
    logic                wr;
    logic                rd;
    logic                is_abs;
    logic                is_quad;
    logic [31:0]         enc_pos;
    logic [12:0]         delta;
    logic [31:0]         inc_pos;
    logic                do_search;
    logic                do_preset;
    logic                do_cancel;

    eptrk_quad u_quad (
        .clock    (clock),
        .srst     (srst),
        .pin_a    (pin_a),
        .pin_b    (pin_b),
        .pin_z    (pin_z),
        .step     (q_step),
        .up       (q_up),
        .quad_err (q_err),
        .marker   (q_mark)
    );

    eptrk_scale u_scale (
        .res       (ser.res),
        .angle     (ser.angle),
        .coarse    (coarse),
        .supported (supported)
    );

    // apb decode; zero wait states
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;
    assign is_abs  = s_r.ctrl[EPTRK_C_ABS] & ~s_r.ctrl[EPTRK_C_QUAD];
    assign is_quad = s_r.ctrl[EPTRK_C_QUAD];
    assign do_search = wr && paddr == EPTRK_A_CMD && pwdata[EPTRK_K_SEARCH];
    assign do_preset = wr && paddr == EPTRK_A_CMD && pwdata[EPTRK_K_PRESET];
    assign do_cancel = wr && paddr == EPTRK_A_CMD && pwdata[EPTRK_K_CANCEL];
    // absolute location is encoder angle plus the stored bias
    assign enc_pos = {{(32-EPTRK_CPR_BITS){1'b0}}, coarse};
    // signed count change since last serial sample, 8192 per rev
    assign delta = coarse - s_r.last_c;
    assign inc_pos = s_r.pos + {{19{delta[12]}}, delta};

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.nvw = 1'b0;
        // register reads, captured in the setup cycle
        s_nxt.rdata = 32'h0;
        if (rd)
        begin
            if (paddr == EPTRK_A_CTRL)
                s_nxt.rdata = {29'h0, s_r.ctrl};
            else if (paddr == EPTRK_A_STAT)
                s_nxt.rdata = {16'h0, s_r.err, 2'h0, s_r.batt_lost,
                    s_r.batt_low, s_r.bias_ok, s_r.run, ser.referenced, s_r.ok};
            else if (paddr == EPTRK_A_POS)
                s_nxt.rdata = s_r.pos;
            else if (paddr == EPTRK_A_LOLIM)
                s_nxt.rdata = s_r.lolim;
            else if (paddr == EPTRK_A_HILIM)
                s_nxt.rdata = s_r.hilim;
            else if (paddr == EPTRK_A_PRESET)
                s_nxt.rdata = s_r.preset;
            else if (paddr == EPTRK_A_REFPOS)
                s_nxt.rdata = s_r.refpos;
            else if (paddr == EPTRK_A_BIAS)
                s_nxt.rdata = s_r.bias;
            else if (paddr == EPTRK_A_FINE)
                s_nxt.rdata = {12'h0, s_r.fine};
        end
        // register writes
        if (wr)
        begin
            if (paddr == EPTRK_A_CTRL)
                s_nxt.ctrl = pwdata[2:0];
            else if (paddr == EPTRK_A_LOLIM)
                s_nxt.lolim = pwdata;
            else if (paddr == EPTRK_A_HILIM)
                s_nxt.hilim = pwdata;
            else if (paddr == EPTRK_A_PRESET)
                s_nxt.preset = pwdata;
            else if (paddr == EPTRK_A_REFPOS)
                s_nxt.refpos = pwdata;
            else if (paddr == EPTRK_A_CMD)
            begin
                if (pwdata[EPTRK_K_CLRERR])
                    s_nxt.err = EPTRK_ERR_NONE;
                s_nxt.run = pwdata[EPTRK_K_RUN];
            end
        end
        // battery reports latch until cleared; new report wins
        if (ser.valid && ser.batt_low)
            s_nxt.batt_low = 1'b1;
        else if (wr && paddr == EPTRK_A_CMD && pwdata[EPTRK_K_CLRERR])
            s_nxt.batt_low = 1'b0;
        if (ser.valid && ser.batt_lost)
            s_nxt.batt_lost = 1'b1;
        else if (wr && paddr == EPTRK_A_CMD && pwdata[EPTRK_K_CLRERR])
            s_nxt.batt_lost = 1'b0;
        if (ser.valid && ser.batt_lost && is_abs)
            s_nxt.bias_ok = 1'b0; // turns are gone, re-reference needed
        // errors after the clear so a same-cycle event is kept
        if (!is_quad && ser.valid && !supported)
            s_nxt.err = EPTRK_ERR_ENCTYP;
        if (s_r.ctrl[EPTRK_C_FOLLOW] && !is_quad)
            s_nxt.err = EPTRK_ERR_FOLLOW;
        if (ser.valid)
            s_nxt.fine = ser.angle; // full resolution for velocity

        case (s_r.st)
            EPTRK_S_DIAG:
            begin
                // restart from power up: flag stays low until rebuilt
                if (diag_done)
                    s_nxt.st = is_abs ? EPTRK_S_QUERY : EPTRK_S_RUN;
                if (nv_valid)
                begin
                    s_nxt.bias    = nv_bias;
                    s_nxt.bias_ok = 1'b1;
                end
                s_nxt.last_c = coarse;
            end
            EPTRK_S_QUERY:
            begin
                // ask referenced status; read angle only when valid
                if (ser.valid && ser.referenced && supported)
                    s_nxt.st = EPTRK_S_READ;
                // no angle known yet, so a preset cannot be honoured
                if (do_preset)
                    s_nxt.err = EPTRK_ERR_NOREF;
            end
            EPTRK_S_READ:
            begin
                if (ser.valid)
                begin
                    s_nxt.pos = enc_pos + s_r.bias;
                    s_nxt.ok  = s_r.bias_ok; // power-up restore
                    s_nxt.last_c = coarse; // incremental deltas start here
                    s_nxt.st  = EPTRK_S_RUN;
                end
            end
            EPTRK_S_RUN, EPTRK_S_SRCH:
            begin
                // position tracking
                if (is_quad)
                begin
                    if (q_step)
                        s_nxt.pos = q_up ? s_r.pos + 32'h1
                                         : s_r.pos - 32'h1;
                end
                else if (ser.valid && supported)
                begin
                    s_nxt.last_c = coarse;
                    // not yet referenced: run as incremental
                    if (is_abs && ser.referenced && s_r.bias_ok)
                        s_nxt.pos = enc_pos + s_r.bias;
                    else
                        s_nxt.pos = inc_pos;
                    if (!is_abs && $signed(inc_pos) > $signed(s_r.hilim))
                        s_nxt.pos = s_r.lolim; // wrap high to low
                    else if (!is_abs && $signed(inc_pos) < $signed(s_r.lolim))
                        s_nxt.pos = s_r.hilim; // wrap low to high
                end
                // quadrature error drops the flag
                if (is_quad && q_err)
                begin
                    s_nxt.ok  = 1'b0;
                    s_nxt.err = EPTRK_ERR_QUAD;
                end
                // preset position command
                if (do_preset)
                begin
                    if (is_abs && !ser.referenced)
                        s_nxt.err = EPTRK_ERR_NOREF; // refused
                    else
                    begin
                        s_nxt.pos = s_r.preset;
                        s_nxt.ok  = 1'b1;
                        if (is_abs)
                        begin
                            s_nxt.bias    = s_r.preset - enc_pos;
                            s_nxt.bias_ok = 1'b1;
                            s_nxt.nvw     = 1'b1;
                        end
                    end
                end
                if (s_r.st == EPTRK_S_RUN && do_search)
                begin
                    // quadrature keeps its flag unless cancel rides along
                    if (!is_quad || do_cancel)
                        s_nxt.ok = 1'b0;
                    if (!do_cancel)
                        s_nxt.st = EPTRK_S_SRCH;
                end
                else if (s_r.st == EPTRK_S_SRCH)
                begin
                    if (do_cancel)
                        s_nxt.st = EPTRK_S_RUN; // flag unchanged; still set if the quadrature search kept it
                    else if ((is_quad && q_mark) ||
                             (!is_quad && ser.valid && ser.marker &&
                              (!is_abs || ser.referenced)))
                    begin
                        s_nxt.pos = s_r.refpos;
                        s_nxt.ok  = 1'b1;
                        s_nxt.st  = EPTRK_S_RUN;
                        if (is_abs && !is_quad)
                        begin
                            s_nxt.bias    = s_r.refpos - enc_pos;
                            s_nxt.bias_ok = 1'b1;
                            s_nxt.nvw     = 1'b1;
                        end
                    end
                end
            end
            default:
                s_nxt.st = EPTRK_S_DIAG;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            s_r       <= '0;
            s_r.st    <= EPTRK_S_DIAG;
            s_r.lolim <= EPTRK_RST_LOLIM;
            s_r.hilim <= EPTRK_RST_HILIM;
        end
        else
            s_r <= s_nxt;
    end

    // outputs
    assign prdata   = s_r.rdata;
    assign pready   = 1'b1;
    assign pslverr  = 1'b0;
    assign ser_query = (s_r.st == EPTRK_S_QUERY);
    assign nv_write = s_r.nvw; // saved at once
    assign nv_wdata = s_r.bias;
    assign position_ok_flag = s_r.ok;
    assign motion_enable = s_r.ok & s_r.run;
    assign axis_pos = s_r.pos;
    assign fine_angle = s_r.fine;
endmodule // eptrk_top
`default_nettype wire

// >>> testbench/eptrk_top_props.sv
// port checker for the position tracking core
`timescale 1ns/1ns
`default_nettype none
module eptrk_top_props
    import eptrk_pkg::*;
(
    // clock and reset
    input wire logic        clock,
    input wire logic        srst,
    // apb slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // status and storage
    input wire logic        ser_query,
    input wire logic        diag_done,
    input wire logic        nv_write,
    input wire logic        position_ok_flag,
    input wire logic        motion_enable
);
    // a command word taken this cycle
    logic cmd_wr;
    assign cmd_wr = psel & penable & pwrite & (paddr == EPTRK_A_CMD);
    // quadrature bit of the control word, mirrored from the bus
    logic quad_r;
    always_ff @(posedge clock)
    begin
        if (srst)
            quad_r <= 1'b0;
        else if (psel && penable && pwrite && paddr == EPTRK_A_CTRL)
            quad_r <= pwdata[EPTRK_C_QUAD];
    end

    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    property p_ready; psel && penable |-> pready && !pslverr; endproperty
    a_ready: assert property (p_ready)
        else $error("apb access not answered cleanly");
    property p_srch_clr;
        cmd_wr && pwdata[EPTRK_K_SEARCH] && (!quad_r || pwdata[EPTRK_K_CANCEL])
            |=> !position_ok_flag;
    endproperty
    a_srch_clr: assert property (p_srch_clr)
        else $error("search start left the flag set");
    // cancel alone must not revive the flag in the two cycles after it
    property p_cancel;
        cmd_wr && pwdata[EPTRK_K_CANCEL] && !pwdata[EPTRK_K_PRESET]
            && !position_ok_flag |=> !position_ok_flag [*2];
    endproperty
    a_cancel: assert property (p_cancel)
        else $error("flag set after cancel");
    property p_motion; !position_ok_flag |-> !motion_enable; endproperty
    a_motion: assert property (p_motion)
        else $error("motion enabled without valid position");
    property p_nv_pulse; nv_write |=> !nv_write; endproperty
    a_nv_pulse: assert property (p_nv_pulse)
        else $error("bias store pulse too long");
    property p_nv_ok; nv_write |-> ##[0:2] position_ok_flag; endproperty
    a_nv_ok: assert property (p_nv_ok)
        else $error("bias stored but flag not set");
    property p_query_diag; !diag_done |-> !ser_query; endproperty
    a_query_diag: assert property (p_query_diag)
        else $error("status query before diagnostics");
    property p_query_ok; ser_query |-> !position_ok_flag; endproperty
    a_query_ok: assert property (p_query_ok)
        else $error("flag set while waiting for status");
endmodule // eptrk_top_props
`default_nettype wire

// >>> testbench/eptrk_enc_model.sv
// serial and quadrature encoder model
`timescale 1ns/1ns
`default_nettype none
module eptrk_enc_model
    import eptrk_pkg::*;
(
    // clock
    input  wire logic       clock,
    // encoder outputs
    output var  eptrk_ser_t ser,
    output logic            pin_a,
    output logic            pin_b,
    output logic            pin_z
);
    logic [1:0] q        = 2'b00;
    logic       low_batt = 1'b0;
    initial
    begin
        ser = '0;
        {pin_a, pin_b, pin_z} = 3'b000;
    end
    // one sample, battery state rides along with it
    task automatic sample(input logic [2:0] res, input logic [19:0] ang,
                          input logic mk, input logic rf);
        @(posedge clock);
        ser <= {1'b1, res, ang, mk, rf, low_batt, 1'b0};
        @(posedge clock);
        ser.valid <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    // gray step; pins settle long enough for the synchronisers
    task automatic step(input logic fwd, input logic both);
        @(posedge clock);
        q = both ? ~q : (fwd ? {q[0], ~q[1]} : {~q[0], q[1]});
        {pin_a, pin_b} <= q;
        repeat (5) @(posedge clock);
    endtask
    // once per revolution marker pulse
    task automatic mark();
        @(posedge clock);
        pin_z <= 1'b1;
        repeat (5) @(posedge clock);
        pin_z <= 1'b0;
        repeat (5) @(posedge clock);
    endtask
endmodule // eptrk_enc_model
`default_nettype wire

// >>> testbench/eptrk_top_bench.sv
// self-checking bench for the position tracking core
`timescale 1ns/1ns
`default_nettype none
module eptrk_top_bench import eptrk_pkg::*;;
    localparam logic [31:0] M_ALL = 32'hffff_ffff;
    localparam logic [31:0] M_ERR = 32'h0000_ff00;
    logic        clock = 1'b0, srst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, nv_bias = 32'h0;
    logic        diag_done = 1'b1, nv_valid = 1'b0;
    logic [31:0] prdata, nv_wdata, axis_pos, rdv, nvw_seen;
    logic        pready, pslverr, ser_query, nv_write;
    logic        position_ok_flag, motion_enable, pin_a, pin_b, pin_z;
    logic [19:0] fine_angle;
    eptrk_ser_t  ser;
    int          errors = 0, checked = 0, d;

    always #20 clock = ~clock;
    eptrk_top i_dut (.clock, .srst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ser, .ser_query, .pin_a,
        .pin_b, .pin_z, .diag_done, .nv_valid, .nv_bias, .nv_write,
        .nv_wdata, .position_ok_flag, .motion_enable, .axis_pos,
        .fine_angle);
    eptrk_enc_model i_enc (.clock, .ser, .pin_a, .pin_b, .pin_z);
    // keep the last stored bias word
    always @(posedge clock)
        if (nv_write === 1'b1)
            nvw_seen <= nv_wdata;

    task automatic final_report();
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // apb transfer; an idle edge follows so psel never toggles twice
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] v);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= v;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rdv = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        xfer(1'b1, a, v);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, e,
                      input string n);
        xfer(1'b0, a, 32'h0);
        cmp(n, rdv & m, e);
    endtask
    task automatic okw(input logic e);
        repeat (3) @(posedge clock);
        cmp("ok", {31'h0, position_ok_flag}, {31'h0, e});
    endtask

    // watchdog sized well past the whole sequence
    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        final_report();
    end

    initial
    begin
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        // serial incremental mode, 64k encoder scaled by eight
        rc(EPTRK_A_LOLIM, M_ALL, EPTRK_RST_LOLIM, "lolim");
        rc(EPTRK_A_HILIM, M_ALL, EPTRK_RST_HILIM, "hilim");
        i_enc.sample(EPTRK_RES_64K, 20'h0, 1'b0, 1'b0);
        wr(EPTRK_A_LOLIM, 32'h10);
        wr(EPTRK_A_HILIM, 32'h20);
        wr(EPTRK_A_PRESET, 32'h1e);
        wr(EPTRK_A_CMD, 32'h2);
        okw(1'b1);
        cmp("pos", axis_pos, 32'h1e);
        i_enc.sample(EPTRK_RES_64K, 20'd40, 1'b0, 1'b0);
        cmp("pos", axis_pos, 32'h10);
        cmp("fine", {12'h0, fine_angle}, 32'd40);
        i_enc.sample(EPTRK_RES_64K, 20'd16, 1'b0, 1'b0);
        cmp("pos", axis_pos, 32'h20);
        wr(EPTRK_A_CMD, 32'h1);
        okw(1'b0);
        i_enc.sample(EPTRK_RES_64K, 20'd16, 1'b1, 1'b0);
        okw(1'b1);
        i_enc.sample(EPTRK_RES_OLD1M, 20'd16, 1'b0, 1'b0);
        rc(EPTRK_A_STAT, M_ERR, 32'h5100, "err");
        wr(EPTRK_A_CMD, 32'h8);
        rc(EPTRK_A_STAT, M_ERR, 32'h0000, "err");
        wr(EPTRK_A_CTRL, 32'h4);
        rc(EPTRK_A_STAT, M_ERR, 32'h5500, "err");
        // quadrature mode
        wr(EPTRK_A_CTRL, 32'h2);
        wr(EPTRK_A_PRESET, 32'h18);
        wr(EPTRK_A_CMD, 32'h12);
        okw(1'b1);
        cmp("run", {31'h0, motion_enable}, 32'h1);
        repeat (4) i_enc.step(1'b1, 1'b0);
        d = axis_pos - 32'h18;
        cmp("dist", {31'h0, d == 4 || d == -4}, 32'h1);
        repeat (2) i_enc.step(1'b0, 1'b0);
        cmp("pos", axis_pos - 32'h18, 32'(d / 2));
        i_enc.step(1'b0, 1'b1);
        okw(1'b0);
        cmp("run", {31'h0, motion_enable}, 32'h0);
        rc(EPTRK_A_STAT, M_ERR, 32'h5400, "err");
        wr(EPTRK_A_CMD, 32'h9);
        okw(1'b0);
        i_enc.mark();
        okw(1'b1);
        wr(EPTRK_A_CMD, 32'h5);
        okw(1'b0);
        // absolute mode from power-up
        srst <= 1'b1;
        diag_done <= 1'b0;
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        wr(EPTRK_A_CTRL, 32'h1);
        diag_done <= 1'b1;
        repeat (4) @(posedge clock);
        cmp("query", {31'h0, ser_query}, 32'h1);
        wr(EPTRK_A_PRESET, 32'h40);
        wr(EPTRK_A_CMD, 32'h2);
        rc(EPTRK_A_STAT, M_ERR, 32'h5300, "err");
        i_enc.low_batt = 1'b1;
        i_enc.sample(EPTRK_RES_64K, 20'd800, 1'b0, 1'b1);
        // status sample first, then the angle read
        i_enc.sample(EPTRK_RES_64K, 20'd800, 1'b0, 1'b1);
        okw(1'b0);
        rc(EPTRK_A_STAT, 32'h10, 32'h10, "batt");
        wr(EPTRK_A_REFPOS, 32'h1000);
        wr(EPTRK_A_CMD, 32'h1);
        i_enc.sample(EPTRK_RES_64K, 20'd800, 1'b1, 1'b1);
        okw(1'b1);
        cmp("pos", axis_pos, 32'h1000);
        cmp("bias", nvw_seen, 32'hf9c);
        i_enc.sample(EPTRK_RES_64K, 20'd1040, 1'b0, 1'b1);
        cmp("pos", axis_pos, 32'h101e);
        wr(EPTRK_A_PRESET, 32'h2000);
        wr(EPTRK_A_CMD, 32'h2);
        okw(1'b1);
        cmp("pos", axis_pos, 32'h2000);
        cmp("bias", nvw_seen, 32'h1f7e);
        wr(EPTRK_A_CMD, 32'h1);
        wr(EPTRK_A_CMD, 32'h4);
        i_enc.sample(EPTRK_RES_64K, 20'd1040, 1'b1, 1'b1);
        okw(1'b0);
        // power cycle after the aborted search
        srst <= 1'b1;
        diag_done <= 1'b0;
        nv_valid <= 1'b1;
        nv_bias <= 32'h1f7e;
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        wr(EPTRK_A_CTRL, 32'h1);
        diag_done <= 1'b1;
        i_enc.sample(EPTRK_RES_64K, 20'd1120, 1'b0, 1'b1);
        i_enc.sample(EPTRK_RES_64K, 20'd1120, 1'b0, 1'b1);
        okw(1'b1);
        cmp("pos", axis_pos, 32'h200a);
        final_report();
    end
endmodule // eptrk_top_bench
bind eptrk_top eptrk_top_props i_props (.clock, .srst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .ser_query, .diag_done,
    .nv_write, .position_ok_flag, .motion_enable);
`default_nettype wire
